// ---- pabdc_top.sv ----
// register file and control logic for eight bias converters
//
// Implementation choice: the strobed register port.
`timescale 1ns/1ns
`default_nettype none
// How it works
// - reset clamps outputs, loads default codes
// - bipolar converters ranged per pair
// - each auxiliary converter ranged alone
// - pair clamp from ref pin, aux to ground
// - bad positive supply forces negative-supply clamp
// - loop bit clear: codes from writes only
// - loop bit set: sensors update bipolar codes
// - loop code above limit loads limit
// - hardware reset recovery within 250 us
// - software reset recovery within 10 us
// - sleep rise turns amplifier off, 1 ms
// - sleep fall turns amplifier on, 0.5 ms
// - negative supply alarm acts within 1 ms
// - buffered codes move async or on trigger
// - data reads return active code
module pabdc_top #(
  parameter int HW_REC_CYC = pabdc_pkg::HW_REC_CYC,
  parameter int PA_OFF_CYC = pabdc_pkg::PA_OFF_CYC,
  parameter int AMPLIFIER_ENABLE_OUT_CYC = pabdc_pkg::AMPLIFIER_ENABLE_OUT_CYC
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic srst_i,
  // register port
  input wire pabdc_pkg::pabdc_bus_s bus_i,
  output logic [15:0] rdata_o,
  // analog side status and pins
  input wire logic positive_analog_supply_ok_i,
  input wire logic negative_analog_supply_alarm_i,
  input wire logic [1:0] sleep_i,
  input wire logic dac_trigger_i,
  // closed-loop controller codes
  input wire pabdc_pkg::pabdc_loop_s loop_i,
  // converter controls
  output logic [7:0][11:0] dac_code_o,
  output logic [7:0] clamp_o,
  output logic avss_clamp_o,
  output logic [7:0] range_sel_o,
  output logic loop_enable_o,
  output logic ready_o,
  output logic amplifier_enable_out_o
);

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  // true when an address selects one register
  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    hit = (a == o);
  endfunction

  // true when an address falls in the converter data block
  function automatic logic data_hit(input logic [7:0] a);
    data_hit = (a >= pabdc_pkg::OFS_DATA_BASE) &&
      (a < pabdc_pkg::OFS_DATA_BASE + 8'(pabdc_pkg::NUM_DAC));
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  pabdc_pkg::pabdc_state_e state_ff; // recovery sequencer
  pabdc_pkg::pabdc_state_e nxt_state;
  logic [15:0] rec_cnt_ff; // recovery cycles elapsed
  logic [15:0] nxt_rec_cnt;
  logic [7:0] loop_cfg_ff; // loop configuration
  logic [7:0] sync_ff; // per converter sync mode
  logic [7:0] clamp_reg_ff; // software clamp bits
  logic [11:0] limit_ff; // closed-loop upper limit
  logic [7:0][11:0] buf_ff; // pending codes
  logic [7:0][11:0] nxt_buf;
  logic [7:0][11:0] nxt_act;
  logic [15:0] pa_cnt_ff; // amplifier enable settle count
  logic [15:0] nxt_pa_cnt;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  wire logic wr = bus_i.wr;
  wire logic [7:0] adr = bus_i.addr;
  wire logic [15:0] wd = bus_i.wdata;
  wire logic running = (state_ff == pabdc_pkg::PABDC_RUN);
  // writes only land once recovery is over
  wire logic wr_ok = wr && running;
  wire logic wr_loop = wr_ok && hit(adr, pabdc_pkg::OFS_LOOP_CFG);
  wire logic wr_sync = wr_ok && hit(adr, pabdc_pkg::OFS_DAC_SYNC);
  wire logic wr_range = wr_ok && hit(adr, pabdc_pkg::OFS_RANGE);
  wire logic wr_clamp = wr_ok && hit(adr, pabdc_pkg::OFS_CLAMP);
  wire logic wr_lim_a = wr_ok && hit(adr, pabdc_pkg::OFS_LIMIT_A);
  wire logic wr_lim_b = wr_ok && hit(adr, pabdc_pkg::OFS_LIMIT_B);
  wire logic wr_data = wr_ok && data_hit(adr);
  wire logic [2:0] data_idx = 3'(adr - pabdc_pkg::OFS_DATA_BASE);
  // software reset and trigger are self-clearing strobes
  wire logic sw_reset = wr_ok && hit(adr, pabdc_pkg::OFS_SOFT_RESET) &&
    wd[pabdc_pkg::SOFT_RESET_BIT];
  wire logic sw_trig = wr_ok && hit(adr, pabdc_pkg::OFS_TRIGGER) &&
    wd[pabdc_pkg::TRIG_BIT];
  wire logic trig = sw_trig || (dac_trigger_i && running);
  wire logic loop_en = loop_cfg_ff[pabdc_pkg::LOOP_EN_BIT];

  // ----------------------------------------------------------------
  // recovery sequencer
  // ----------------------------------------------------------------
  wire logic hw_done = (rec_cnt_ff >= 16'(HW_REC_CYC - 1));
  wire logic sw_done = (rec_cnt_ff >= 16'(pabdc_pkg::SW_REC_CYC - 1));

  always_comb begin
    nxt_state = state_ff;
    nxt_rec_cnt = rec_cnt_ff + 16'h0001;
    unique case (state_ff)
      pabdc_pkg::PABDC_HW_REC: begin
        if (hw_done) begin
          nxt_state = pabdc_pkg::PABDC_RUN;
        end
      end
      pabdc_pkg::PABDC_SW_REC: begin
        if (sw_done) begin
          nxt_state = pabdc_pkg::PABDC_RUN;
        end
      end
      // normal operation
      pabdc_pkg::PABDC_RUN: begin
        nxt_rec_cnt = 16'h0000;
        if (sw_reset) begin
          nxt_state = pabdc_pkg::PABDC_SW_REC;
        end
      end
      default: begin
        nxt_state = pabdc_pkg::PABDC_HW_REC;
        nxt_rec_cnt = 16'h0000;
      end
    endcase
  end

  // sequencer registers; hardware reset restarts the long wait
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      state_ff <= pabdc_pkg::PABDC_HW_REC;
      rec_cnt_ff <= 16'h0000;
    end else begin
      state_ff <= nxt_state;
      rec_cnt_ff <= nxt_rec_cnt;
    end
  end

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  wire logic init = srst_i || sw_reset;
  // clamp bits held by a sleep pin: pair a and aux 1-2, pair b and aux 3-4
  wire logic [7:0] sleep_force = {2'b00, {2{sleep_i[1]}},
    {2{sleep_i[0]}}, sleep_i[1], sleep_i[0]};

  // configuration stores; both resets load defaults
  always_ff @(posedge mclk_i) begin
    if (init) begin
      loop_cfg_ff <= pabdc_pkg::LOOP_CFG_DEFAULT;
      sync_ff <= pabdc_pkg::SYNC_DEFAULT;
      range_sel_o <= pabdc_pkg::RANGE_DEFAULT;
      clamp_reg_ff <= pabdc_pkg::CLAMP_DEFAULT;
      limit_ff <= pabdc_pkg::LIMIT_DEFAULT;
    end else begin
      if (wr_loop) begin
        loop_cfg_ff <= wd[7:0];
      end
      if (wr_sync) begin
        sync_ff <= wd[7:0];
      end
      if (wr_range) begin
        range_sel_o <= wd[7:0];
      end
      // clamp bits forced by sleep ignore writes
      if (wr_clamp) begin
        clamp_reg_ff <= (wd[7:0] & ~sleep_force) |
          (clamp_reg_ff & sleep_force);
      end
      if (wr_lim_a) begin
        limit_ff[7:0] <= wd[7:0];
      end
      if (wr_lim_b) begin
        limit_ff[11:8] <= wd[3:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // per converter code path
  // ----------------------------------------------------------------
  // unsigned limit on loop codes
  wire logic [11:0] loop_lim = (loop_i.code > limit_ff) ?
    limit_ff : loop_i.code;

  genvar gi;
  generate
    for (gi = 0; gi < pabdc_pkg::NUM_DAC; gi++) begin : g_dac
      wire logic my_wr = wr_data && (data_idx == 3'(gi));
      wire logic bip = (gi < pabdc_pkg::NUM_BIP);
      // sensor loop owns the bipolar codes
      wire logic loop_hit = bip && loop_en && running &&
        loop_i.valid && (loop_i.idx == 2'(gi));
      wire logic host_ok = !(bip && loop_en);
      wire logic xfer = host_ok && (sync_ff[gi] ? trig :
        (my_wr && !sync_ff[gi]));
      assign nxt_buf[gi] = my_wr ? wd[11:0] : buf_ff[gi];
      assign nxt_act[gi] = loop_hit ? loop_lim :
        (xfer ? nxt_buf[gi] : dac_code_o[gi]);
    end
  endgenerate

  // code registers; both resets load defaults
  always_ff @(posedge mclk_i) begin
    if (init) begin
      buf_ff <= {pabdc_pkg::NUM_DAC{pabdc_pkg::DAC_DEFAULT}};
      dac_code_o <= {pabdc_pkg::NUM_DAC{pabdc_pkg::DAC_DEFAULT}};
    end else begin
      buf_ff <= nxt_buf;
      dac_code_o <= nxt_act;
    end
  end

  // ----------------------------------------------------------------
  // clamp outputs
  // ----------------------------------------------------------------
  wire logic [7:0] clamp_src = clamp_reg_ff | sleep_force;
  // bipolar clamp from pair bit, aux from own bit
  wire logic [7:0] clamp_map = {
    clamp_src[pabdc_pkg::CLAMP_AUX_LSB +: 4],
    {2{clamp_src[1]}}, {2{clamp_src[0]}}};
  wire logic bad_supply = !positive_analog_supply_ok_i;

  // clamp flags; level for bipolar comes from the pair reference pin
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      clamp_o <= 8'hFF;
      avss_clamp_o <= 1'b0;
    end else begin
      clamp_o <= running && !sw_reset ? clamp_map : 8'hFF;
      avss_clamp_o <= bad_supply;
    end
  end

  // ----------------------------------------------------------------
  // amplifier enable timing
  // ----------------------------------------------------------------
  // off request from either sleep pin or the supply alarm
  wire logic pa_want_on = !(|sleep_i) && !negative_analog_supply_alarm_i;
  wire logic pa_diff = (pa_want_on != amplifier_enable_out_o);
  wire logic [15:0] pa_lim = pa_want_on ? 16'(AMPLIFIER_ENABLE_OUT_CYC - 1) :
    16'(PA_OFF_CYC - 1);
  wire logic pa_flip = pa_diff && (pa_cnt_ff >= pa_lim);
  // count while the request differs, restart when it agrees again
  assign nxt_pa_cnt = (pa_diff && !pa_flip) ?
    pa_cnt_ff + 16'h0001 : 16'h0000;

  // enable output register
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      amplifier_enable_out_o <= 1'b1;
      pa_cnt_ff <= 16'h0000;
    end else begin
      pa_cnt_ff <= nxt_pa_cnt;
      if (pa_flip) begin
        amplifier_enable_out_o <= pa_want_on;
      end
    end
  end

  // ----------------------------------------------------------------
  // status and read path
  // ----------------------------------------------------------------
  wire logic [15:0] status = {12'h000, loop_en, amplifier_enable_out_o,
    avss_clamp_o, running};
  wire logic [15:0] rd_mux =
    data_hit(adr) ? {4'h0, dac_code_o[data_idx]} :
    hit(adr, pabdc_pkg::OFS_LOOP_CFG) ? {8'h00, loop_cfg_ff} :
    hit(adr, pabdc_pkg::OFS_DAC_SYNC) ? {8'h00, sync_ff} :
    hit(adr, pabdc_pkg::OFS_RANGE) ? {8'h00, range_sel_o} :
    hit(adr, pabdc_pkg::OFS_CLAMP) ? {8'h00, clamp_reg_ff} :
    hit(adr, pabdc_pkg::OFS_LIMIT_A) ? {8'h00, limit_ff[7:0]} :
    hit(adr, pabdc_pkg::OFS_LIMIT_B) ? {12'h000, limit_ff[11:8]} :
    hit(adr, pabdc_pkg::OFS_STATUS) ? status : 16'h0000;

  // read data stands one cycle after the strobe, zero otherwise
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      rdata_o <= 16'h0000;
      ready_o <= 1'b0;
      loop_enable_o <= 1'b0;
    end else begin
      rdata_o <= bus_i.rd ? rd_mux : 16'h0000;
      ready_o <= (nxt_state == pabdc_pkg::PABDC_RUN);
      loop_enable_o <= loop_en;
    end
  end

endmodule
`default_nettype wire

// ---- pabdc_pkg.sv ----
// constants and carrier types for the bias converter control block
package pabdc_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_LOOP_CFG = 8'h10;
  localparam logic [7:0] OFS_DAC_SYNC = 8'h15;
  localparam logic [7:0] OFS_RANGE = 8'h16;
  localparam logic [7:0] OFS_CLAMP = 8'h17;
  localparam logic [7:0] OFS_TRIGGER = 8'h1C;
  localparam logic [7:0] OFS_SOFT_RESET = 8'h1E;
  localparam logic [7:0] OFS_STATUS = 8'h20;
  localparam logic [7:0] OFS_DATA_BASE = 8'h30;
  localparam logic [7:0] OFS_LIMIT_A = 8'h4E;
  localparam logic [7:0] OFS_LIMIT_B = 8'h4F;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int NUM_DAC = 8;
  localparam int NUM_BIP = 4;
  localparam int LOOP_EN_BIT = 0;
  localparam int TRIG_BIT = 0;
  localparam int SOFT_RESET_BIT = 0;
  localparam int AUX_RANGE_LSB = 4;
  localparam int CLAMP_AUX_LSB = 2;
  localparam logic [11:0] DAC_DEFAULT = 12'h000;
  localparam logic [11:0] LIMIT_DEFAULT = 12'hFFF;
  localparam logic [7:0] LOOP_CFG_DEFAULT = 8'h00;
  localparam logic [7:0] SYNC_DEFAULT = 8'h00;
  localparam logic [7:0] RANGE_DEFAULT = 8'h00;
  localparam logic [7:0] CLAMP_DEFAULT = 8'h00;

  // bipolar pair range codes, two bits per pair
  localparam logic [1:0] BIP_RANGE_0_TO_5 = 2'h0;
  localparam logic [1:0] BIP_RANGE_M5_TO_0 = 2'h1;
  localparam logic [1:0] BIP_RANGE_M4_TO_1 = 2'h2;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 50;
  localparam int HW_RESET_MAX_US = 250;
  localparam int SW_RESET_MAX_US = 10;
  localparam int PA_OFF_MAX_US = 1000;
  localparam int AMPLIFIER_ENABLE_OUT_MAX_US = 500;
  localparam int HW_REC_CYC = HW_RESET_MAX_US * CLK_MHZ;
  localparam int SW_REC_CYC = SW_RESET_MAX_US * CLK_MHZ;
  localparam int PA_OFF_CYC = PA_OFF_MAX_US * CLK_MHZ;
  localparam int AMPLIFIER_ENABLE_OUT_CYC = AMPLIFIER_ENABLE_OUT_MAX_US * CLK_MHZ;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PABDC_HW_REC = 2'b00,
    PABDC_SW_REC = 2'b01,
    PABDC_RUN = 2'b10
  } pabdc_state_e;

  typedef struct packed {
    logic [7:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } pabdc_bus_s;

  typedef struct packed {
    logic valid;
    logic [1:0] idx;
    logic [11:0] code;
  } pabdc_loop_s;

endpackage

// ---- pabdc_assertions.sv ----
// checker for the bias converter control block
`timescale 1ns/1ns
`default_nettype none
module pabdc_assertions #(
  parameter int HW_REC_CYC = pabdc_pkg::HW_REC_CYC,
  parameter int PA_OFF_CYC = pabdc_pkg::PA_OFF_CYC,
  parameter int AMPLIFIER_ENABLE_OUT_CYC = pabdc_pkg::AMPLIFIER_ENABLE_OUT_CYC
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic srst_i,
  // register port
  input wire pabdc_pkg::pabdc_bus_s bus_i,
  input wire logic [15:0] rdata_o,
  // pins and loop codes
  input wire logic positive_analog_supply_ok_i,
  input wire logic negative_analog_supply_alarm_i,
  input wire logic [1:0] sleep_i,
  input wire logic dac_trigger_i,
  input wire pabdc_pkg::pabdc_loop_s loop_i,
  // converter controls
  input wire logic [7:0][11:0] dac_code_o,
  input wire logic [7:0] clamp_o,
  input wire logic avss_clamp_o,
  input wire logic [7:0] range_sel_o,
  input wire logic loop_enable_o,
  input wire logic ready_o,
  input wire logic amplifier_enable_out_o
);
  // ----------------------------------------------------------------
  // helper state
  // ----------------------------------------------------------------
  // loose bound covers either recovery length
  localparam int REC_LIM = HW_REC_CYC + pabdc_pkg::SW_REC_CYC + 2;
  wire want_on = !(|sleep_i || negative_analog_supply_alarm_i);
  wire wr_ok = ready_o && bus_i.wr;
  wire [11:0] rd_code = dac_code_o[bus_i.addr[2:0]];
  logic [11:0] lim_ff; // mirrored loop limit
  logic [11:0] exp_ff; // expected clipped loop code
  logic [1:0] idx_ff; // converter of last loop code
  int diff_ff; // cycles enable differs from request
  int rec_ff; // cycles spent not ready
  // mirror the limit, defaults on either reset
  always_ff @(posedge mclk_i) begin
    if (srst_i || (wr_ok && bus_i.addr == pabdc_pkg::OFS_SOFT_RESET
        && bus_i.wdata[0]))
      lim_ff <= 12'hFFF;
    else if (wr_ok && bus_i.addr == pabdc_pkg::OFS_LIMIT_A)
      lim_ff[7:0] <= bus_i.wdata[7:0];
    else if (wr_ok && bus_i.addr == pabdc_pkg::OFS_LIMIT_B)
      lim_ff[11:8] <= bus_i.wdata[3:0];
  end
  // expected code for a loop update
  always_ff @(posedge mclk_i) begin
    idx_ff <= loop_i.idx;
    exp_ff <= (loop_i.code > lim_ff) ? lim_ff : loop_i.code;
  end
  // count mismatch of enable and request
  always_ff @(posedge mclk_i) begin
    if (srst_i || amplifier_enable_out_o == want_on) diff_ff <= 0;
    else diff_ff <= diff_ff + 1;
  end
  // count cycles out of normal operation
  always_ff @(posedge mclk_i) begin
    if (srst_i || ready_o) rec_ff <= 0;
    else rec_ff <= rec_ff + 1;
  end
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (srst_i);
  reset_clamp_a: assert property (
    $fell(srst_i) |-> clamp_o == 8'hFF && dac_code_o == '0 && !ready_o)
    else $error("reset did not clamp and clear codes");
  avss_clamp_a: assert property (
    !$past(srst_i) |-> avss_clamp_o == !$past(positive_analog_supply_ok_i))
    else $error("supply clamp does not follow supply state");
  range_write_a: assert property (
    wr_ok && bus_i.addr == pabdc_pkg::OFS_RANGE
    |=> range_sel_o == $past(bus_i.wdata[7:0]))
    else $error("range output differs from written value");
  read_active_a: assert property (
    bus_i.rd && bus_i.addr[7:3] == 5'h06 |=> rdata_o == {4'h0, $past(rd_code)})
    else $error("data read differs from active code");
  idle_read_a: assert property (
    !bus_i.rd |=> rdata_o == 16'h0000)
    else $error("read data present without a read");
  loop_limit_a: assert property (
    loop_i.valid && loop_enable_o && ready_o |=> dac_code_o[idx_ff] == exp_ff)
    else $error("loop code not clipped to limit");
  open_loop_a: assert property (
    loop_i.valid && !loop_enable_o && !bus_i.wr && !dac_trigger_i
    |=> $stable(dac_code_o))
    else $error("loop code taken in open loop");
  amp_off_a: assert property (
    amplifier_enable_out_o && !want_on |-> diff_ff <= PA_OFF_CYC)
    else $error("amplifier switched off too late");
  amp_on_a: assert property (
    !amplifier_enable_out_o && want_on |-> diff_ff <= AMPLIFIER_ENABLE_OUT_CYC)
    else $error("amplifier switched on too late");
  ready_rec_a: assert property (
    !ready_o |-> rec_ff <= REC_LIM)
    else $error("recovery from reset too long");
  cover property (loop_i.valid && loop_enable_o && loop_i.code > lim_ff);
  cover property ($fell(amplifier_enable_out_o));
  cover property (wr_ok && bus_i.addr == pabdc_pkg::OFS_SOFT_RESET);
endmodule
bind pabdc_top pabdc_assertions #(.HW_REC_CYC(HW_REC_CYC),
  .PA_OFF_CYC(PA_OFF_CYC), .AMPLIFIER_ENABLE_OUT_CYC(AMPLIFIER_ENABLE_OUT_CYC)) pabdc_assertions_i (
  .mclk_i(mclk_i), .srst_i(srst_i), .bus_i(bus_i), .rdata_o(rdata_o),
  .positive_analog_supply_ok_i(positive_analog_supply_ok_i),
  .negative_analog_supply_alarm_i(negative_analog_supply_alarm_i),
  .sleep_i(sleep_i), .dac_trigger_i(dac_trigger_i), .loop_i(loop_i),
  .dac_code_o(dac_code_o), .clamp_o(clamp_o), .avss_clamp_o(avss_clamp_o),
  .range_sel_o(range_sel_o), .loop_enable_o(loop_enable_o),
  .ready_o(ready_o), .amplifier_enable_out_o(amplifier_enable_out_o));
`default_nettype wire

// ---- pabdc_bench.sv ----
// self-checking bench for the bias converter control block
`timescale 1ns/1ns
`default_nettype none
module pabdc_bench;
  // ----------------------------------------------------------------
  // signals, model and helpers
  // ----------------------------------------------------------------
  localparam int OFF_CYC = 16; // shortened off delay
  localparam int ON_CYC = 8; // shortened on delay
  logic mclk_i = 1'b0;
  logic srst_i = 1'b1;
  pabdc_pkg::pabdc_bus_s bus_i = '0;
  pabdc_pkg::pabdc_loop_s loop_i = '0;
  logic pos_ok = 1'b1;
  logic alarm = 1'b0;
  logic [1:0] sleep_i = 2'b00;
  logic trig = 1'b0;
  logic [15:0] rdata_o;
  logic [7:0][11:0] dac_code_o;
  logic [7:0] clamp_o, range_sel_o;
  logic avss_o, loop_en_o, ready_o, amp_o;
  int n_mismatch = 0;
  int cmp_count = 0;
  integer seed = 46;
  logic [11:0] mcode [8]; // model of active codes
  logic [11:0] c;
  logic [7:0] r;
  int i;
  pabdc_top #(.HW_REC_CYC(20), .PA_OFF_CYC(OFF_CYC), .AMPLIFIER_ENABLE_OUT_CYC(ON_CYC))
    pabdc_top_i (.mclk_i(mclk_i), .srst_i(srst_i), .bus_i(bus_i),
    .rdata_o(rdata_o), .positive_analog_supply_ok_i(pos_ok),
    .negative_analog_supply_alarm_i(alarm), .sleep_i(sleep_i),
    .dac_trigger_i(trig), .loop_i(loop_i), .dac_code_o(dac_code_o),
    .clamp_o(clamp_o), .avss_clamp_o(avss_o), .range_sel_o(range_sel_o),
    .loop_enable_o(loop_en_o), .ready_o(ready_o),
    .amplifier_enable_out_o(amp_o));
  // free-running clock
  initial forever #10 mclk_i = ~mclk_i;
  task automatic chk(input string nm, input logic [15:0] e,
      input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one-cycle register write
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge mclk_i);
    bus_i <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk_i);
    bus_i.wr <= 1'b0;
  endtask
  // one-cycle register read, data checked in the next cycle
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge mclk_i);
    bus_i <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge mclk_i);
    bus_i.rd <= 1'b0;
    @(negedge mclk_i);
    chk("rdata", e, rdata_o);
  endtask
  // one loop code, then check the active code
  task automatic lp(input logic [1:0] x, input logic [11:0] v,
      input logic [11:0] e);
    @(posedge mclk_i);
    loop_i <= '{valid: 1'b1, idx: x, code: v};
    @(posedge mclk_i);
    loop_i.valid <= 1'b0;
    @(negedge mclk_i);
    chk("loop", {4'h0, e}, {4'h0, dac_code_o[x]});
  endtask
  // change request, enable must hold then flip
  task automatic amp(input logic [1:0] s, input logic a, input logic v,
      input int n);
    @(posedge mclk_i);
    sleep_i <= s;
    alarm <= a;
    repeat (n - 2) @(posedge mclk_i);
    #1 chk("amp early", {15'h0, !v}, {15'h0, amp_o});
    repeat (4) @(posedge mclk_i);
    #1 chk("amp", {15'h0, v}, {15'h0, amp_o});
  endtask
  // bounded wait for normal operation
  task automatic wait_ready(input int lim);
    int n;
    n = 0;
    while (ready_o !== 1'b1 && n < lim) begin
      @(posedge mclk_i);
      n++;
    end
    chk("ready", 16'h0001, {15'h0, ready_o});
  endtask
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // watchdog cuts a hang short
  initial begin
    repeat (20000) @(posedge mclk_i);
    n_mismatch++;
    end_of_test();
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (6) @(posedge mclk_i);
    srst_i <= 1'b0;
    @(negedge mclk_i);
    chk("rclamp", 16'h00FF, {8'h00, clamp_o});
    chk("rcode", 16'h0000, {4'h0, dac_code_o[5]});
    wait_ready(22);
    for (i = 0; i < 8; i++) begin
      c = 12'($random(seed));
      mcode[i] = c;
      wr(8'(8'h30 + i), {4'h0, c});
      @(negedge mclk_i);
      chk("code", {4'h0, mcode[i]}, {4'h0, dac_code_o[i]});
      rd(8'(8'h30 + i), {4'h0, mcode[i]});
    end
    // sync mode waits for pin or bit trigger
    wr(8'h15, 16'h00FF);
    wr(8'h30, 16'h0ABC);
    rd(8'h30, {4'h0, mcode[0]});
    @(posedge mclk_i);
    trig <= 1'b1;
    @(posedge mclk_i);
    trig <= 1'b0;
    @(negedge mclk_i);
    chk("pin trig", 16'h0ABC, {4'h0, dac_code_o[0]});
    wr(8'h31, 16'h0123);
    wr(8'h1C, 16'h0001);
    @(negedge mclk_i);
    chk("bit trig", 16'h0123, {4'h0, dac_code_o[1]});
    rd(8'hFF, 16'h0000);
    // every pair range, random aux ranges
    for (i = 0; i < 3; i++) begin
      r = {4'($random(seed)), 2'(i), 2'(2 - i)};
      wr(8'h16, {8'h00, r});
      @(negedge mclk_i);
      chk("range", {8'h00, r}, {8'h00, range_sel_o});
      rd(8'h16, {8'h00, r});
    end
    lp(2'd2, 12'h555, mcode[2]);
    wr(8'h4E, 16'h0000);
    wr(8'h4F, 16'h0008);
    wr(8'h10, 16'h0001);
    // loop enable output trails the register by one cycle
    @(posedge mclk_i);
    @(negedge mclk_i);
    chk("loop en", 16'h0001, {15'h0, loop_en_o});
    for (i = 0; i < 12; i++) begin
      c = (i < 3) ? 12'(12'h7FF + i) : 12'($random(seed));
      lp(2'(i), c, (c > 12'h800) ? 12'h800 : c);
    end
    @(posedge mclk_i);
    pos_ok <= 1'b0;
    @(posedge mclk_i);
    @(negedge mclk_i);
    chk("avss", 16'h0001, {15'h0, avss_o});
    // supply returns on a rising edge like every other input
    @(posedge mclk_i);
    pos_ok <= 1'b1;
    // sleep and alarm drive the enable
    amp(2'b01, 1'b0, 1'b0, OFF_CYC);
    amp(2'b00, 1'b0, 1'b1, ON_CYC);
    amp(2'b10, 1'b0, 1'b0, OFF_CYC);
    amp(2'b00, 1'b0, 1'b1, ON_CYC);
    amp(2'b00, 1'b1, 1'b0, OFF_CYC);
    amp(2'b00, 1'b0, 1'b1, ON_CYC);
    wr(8'h1E, 16'h0001);
    @(posedge mclk_i);
    @(negedge mclk_i);
    chk("sclamp", 16'h00FF, {8'h00, clamp_o});
    chk("sready", 16'h0000, {15'h0, ready_o});
    wait_ready(pabdc_pkg::SW_REC_CYC + 2);
    for (i = 0; i < 8; i++) begin
      chk("scode", 16'h0000, {4'h0, dac_code_o[i]});
    end
    rd(8'h16, 16'h0000);
    end_of_test();
  end
endmodule
`default_nettype wire
